// >>> dacseq_pkg.sv
// constants and types for the serial command and converter control block
// How it works
// - sixteen-bit frames, sampled on clock falling edges
// - command executes when frame select rises
// - bit15 low writes a control register
// - bit15 high writes channel input register
// - separate input and output register per channel
// - codes are straight binary zero to 4095
// - mode 00 copies new data immediately
// - mode 01 holds outputs unchanged
// - mode 10 copies all inputs at once
// - address 0111 holds readback select, mode
// - broadcast bit loads every channel enabled at address 0101
// - address 0011 general purpose control fields
// - one shared range bit each converter
// - address 1011 power down and reference
// - channel power-down tristates that dac output
// - output register kept through power-down
// - global power-down stops dac drives, reference and adc buffer together
// - dac pin still convertible by adc sequence
// - sequencer steps to next selected channel
// - sequence write puts first channel tracking
// - first select fall converts first channel
// - conversion lasts 2 us, no overlap
`default_nettype none
package dacseq_pkg;
  localparam int NCH = 8;
  localparam int CODE_W = 12;
  localparam int CLK_HZ = 20_000_000;
  localparam int CONV_NS = 2000;
  localparam int CONV_CYC = (CONV_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [3:0] ADDR_SEQ = 4'h2;
  localparam logic [3:0] ADDR_GP = 4'h3;
  localparam logic [3:0] ADDR_DAC_CFG = 4'h5;
  localparam logic [3:0] ADDR_RB = 4'h7;
  localparam logic [3:0] ADDR_PD = 4'hb;
  localparam int GP_PRECH = 9;
  localparam int GP_BUFEN = 8;
  localparam int GP_LOCK = 7;
  localparam int GP_BCAST = 6;
  localparam int GP_ADCR = 5;
  localparam int GP_DACR = 4;
  localparam int GLOBAL_PD_BIT = 10;
  localparam int PD_REF_BIT = 9;
  localparam logic [1:0] MODE_IMM = 2'h0;
  localparam logic [1:0] MODE_HOLD = 2'h1;
  localparam logic [1:0] MODE_LOAD = 2'h2;
  localparam logic [10:0] REG_RST = 11'h000;
  typedef enum logic [1:0] {DS_IDLE, DS_TRACK, DS_CONV} dacseq_state_t;
endpackage
`default_nettype wire

// >>> dacseq_if.sv
// frame handoff between the serial receiver and the control logic
`timescale 1ns/100ps
`default_nettype none
interface dacseq_if;
  logic frame_done;
  logic frame_start;
  logic [15:0] frame;
  modport rx (output frame_done, output frame_start, output frame);
  modport ctl (input frame_done, input frame_start, input frame);
endinterface
`default_nettype wire

// >>> dacseq_rx.sv
// serial receiver: synchronises pins and assembles sixteen-bit frames
`timescale 1ns/100ps
`default_nettype none
module dacseq_rx (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic sclk_in,
  input wire logic sync_n_in,
  input wire logic sdi_in,
  dacseq_if.rx fr
);
  logic [2:0] s1, s2;
  logic sclk_q, sync_q;
  logic [15:0] shreg;
  logic [4:0] cnt;
  wire fall = sclk_q & ~s2[0];
  wire rise_sync = ~sync_q & s2[1];
  wire fall_sync = sync_q & ~s2[1];
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1 <= 3'h2;
      s2 <= 3'h2;
      sclk_q <= 1'b0;
      sync_q <= 1'b1;
    end else begin
      s1 <= {sdi_in, sync_n_in, sclk_in};
      s2 <= s1;
      sclk_q <= s2[0];
      sync_q <= s2[1];
    end
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shreg <= 16'h0000;
      cnt <= 5'h00;
    end else if (fall_sync) begin
      cnt <= 5'h00;
    end else if (fall && !s2[1] && cnt != 5'h10) begin
      shreg <= {shreg[14:0], s2[2]};
      cnt <= cnt + 5'h01;
    end
  end
  // executes only after the sixteenth edge; short frames are dropped
  assign fr.frame_done = rise_sync && cnt == 5'h10;
  assign fr.frame_start = fall_sync;
  assign fr.frame = shreg;
endmodule
`default_nettype wire

// >>> dacseq_top.sv
// control logic: register decode, dac two-stage update, adc sequencer
`timescale 1ns/100ps
`default_nettype none
module dacseq_top
  import dacseq_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // serial port
  input wire logic sclk_in,
  input wire logic sync_n_in,
  input wire logic sdi_in,
  // dac outputs
  output logic [NCH*CODE_W-1:0] dac_code_out,
  output logic [NCH-1:0] dac_drive_out,
  output logic dac_gain2_out,
  // shared analog controls
  output logic adc_gain2_out,
  output logic adc_buf_en_out,
  output logic adc_prech_out,
  output logic ref_en_out,
  output logic lock_out,
  output logic [4:0] readback_sel_out,
  // adc sequencer
  output logic [2:0] adc_mux_out,
  output logic adc_track_out,
  output logic adc_convert_out
);
  dacseq_if fr ();
  dacseq_rx u_rx (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .sclk_in(sclk_in),
    .sync_n_in(sync_n_in),
    .sdi_in(sdi_in),
    .fr(fr)
  );

  function automatic logic [2:0] next_chan(input logic [7:0] sel, input logic [2:0] cur,
                                           input logic from_start);
    logic [2:0] r;
    logic hit;
    r = 3'h0;
    hit = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (!hit && sel[i] && (from_start || i > int'(cur))) begin
        r = 3'(i);
        hit = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic more_after(input logic [7:0] sel, input logic [2:0] cur);
    logic m;
    m = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (sel[i] && i > int'(cur)) begin
        m = 1'b1;
      end
    end
    return m;
  endfunction

  logic [10:0] gp_reg, rb_reg, pd_reg;
  logic [7:0] dac_cfg, seq_sel;
  logic seq_rep;
  logic [CODE_W-1:0] in_reg [NCH];
  logic [CODE_W-1:0] out_reg [NCH];
  dacseq_state_t state;
  logic [2:0] chan;
  logic [7:0] conv_cnt;

  wire done = fr.frame_done;
  wire is_dac = fr.frame[15];
  wire is_ctl = ~fr.frame[15];
  wire [3:0] ctl_addr = fr.frame[14:11];
  wire [8:0] ctl_data = fr.frame[8:0];
  wire [10:0] ctl_word = fr.frame[10:0];
  wire [2:0] dac_addr = fr.frame[14:12];
  wire [CODE_W-1:0] dac_data = fr.frame[11:0];
  wire bcast = gp_reg[GP_BCAST];
  wire [1:0] mode = rb_reg[1:0];
  wire gp_wr = done && is_ctl && ctl_addr == ADDR_GP;
  wire rb_wr = done && is_ctl && ctl_addr == ADDR_RB;
  wire pd_wr = done && is_ctl && ctl_addr == ADDR_PD;
  wire cfg_wr = done && is_ctl && ctl_addr == ADDR_DAC_CFG;
  wire seq_wr = done && is_ctl && ctl_addr == ADDR_SEQ;
  wire load_all = rb_wr && ctl_word[1:0] == MODE_LOAD;
  wire global_power_down = pd_reg[GLOBAL_PD_BIT];
  wire conv_end = state == DS_CONV && conv_cnt == 8'(CONV_CYC - 1);

  // control registers; reserved bits are stored as zero
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gp_reg <= REG_RST;
      rb_reg <= REG_RST;
      pd_reg <= REG_RST;
      dac_cfg <= 8'h00;
    end else begin
      if (gp_wr) gp_reg <= {1'b0, ctl_word[9:4], 4'h0};
      if (rb_wr) rb_reg <= {4'h0, ctl_word[6:0]};
      if (pd_wr) pd_reg <= {ctl_word[10:9], 1'b0, ctl_word[7:0]};
      if (cfg_wr) dac_cfg <= ctl_data[7:0];
    end
  end

  // input and output register stages per channel
  genvar g;
  for (g = 0; g < NCH; g++) begin : g_ch
    wire sel = bcast ? dac_cfg[g] : dac_addr == 3'(g);
    wire wr = done && is_dac && sel;
    always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        in_reg[g] <= 12'h000;
        out_reg[g] <= 12'h000;
      end else begin
        if (wr) in_reg[g] <= dac_data;
        if (wr && mode == MODE_IMM) out_reg[g] <= dac_data;
        else if (load_all) out_reg[g] <= in_reg[g];
      end
    end
    // power-down only gates drive, so the held code comes back
    always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        dac_code_out[g*CODE_W +: CODE_W] <= 12'h000;
        dac_drive_out[g] <= 1'b0;
      end else begin
        dac_code_out[g*CODE_W +: CODE_W] <= out_reg[g];
        dac_drive_out[g] <= dac_cfg[g] && !pd_reg[g] && !global_power_down;
      end
    end
  end

  // adc sequencer; dac pins are not excluded so they can be monitored
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= DS_IDLE;
      chan <= 3'h0;
      conv_cnt <= 8'h00;
      seq_sel <= 8'h00;
      seq_rep <= 1'b0;
    end else if (seq_wr) begin
      seq_sel <= ctl_data[7:0];
      seq_rep <= ctl_word[9];
      chan <= next_chan(ctl_data[7:0], 3'h0, 1'b1);
      state <= (ctl_data[7:0] != 8'h00 && !global_power_down) ? DS_TRACK : DS_IDLE;
      conv_cnt <= 8'h00;
    end else begin
      unique case (state)
        DS_IDLE: ;
        DS_TRACK: begin
          if (fr.frame_start && !global_power_down) begin
            state <= DS_CONV;
            conv_cnt <= 8'h00;
          end
        end
        DS_CONV: begin
          if (conv_end) begin
            if (more_after(seq_sel, chan)) begin
              chan <= next_chan(seq_sel, chan, 1'b0);
              state <= DS_TRACK;
            end else if (seq_rep) begin
              chan <= next_chan(seq_sel, chan, 1'b1);
              state <= DS_TRACK;
            end else begin
              state <= DS_IDLE;
            end
          end else begin
            conv_cnt <= conv_cnt + 8'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dac_gain2_out <= 1'b0;
      adc_gain2_out <= 1'b0;
      adc_buf_en_out <= 1'b0;
      adc_prech_out <= 1'b0;
      ref_en_out <= 1'b0;
      lock_out <= 1'b0;
      readback_sel_out <= 5'h00;
      adc_mux_out <= 3'h0;
      adc_track_out <= 1'b0;
      adc_convert_out <= 1'b0;
    end else begin
      dac_gain2_out <= gp_reg[GP_DACR];
      adc_gain2_out <= gp_reg[GP_ADCR];
      adc_buf_en_out <= gp_reg[GP_BUFEN] && !global_power_down;
      adc_prech_out <= gp_reg[GP_PRECH];
      ref_en_out <= pd_reg[PD_REF_BIT] && !global_power_down;
      lock_out <= gp_reg[GP_LOCK];
      readback_sel_out <= rb_reg[6:2];
      adc_mux_out <= chan;
      adc_track_out <= state == DS_TRACK;
      adc_convert_out <= state == DS_CONV;
    end
  end

  // checks look at the register stages, not only the pins
  property p_imm;
    @(posedge clk_in) disable iff (!nrst_in)
      (done && is_dac && !bcast && mode == MODE_IMM) |=> out_reg[$past(dac_addr)] == $past(dac_data);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate mode did not update");
  property p_hold;
    @(posedge clk_in) disable iff (!nrst_in)
      (mode == MODE_HOLD && !load_all) |=> $stable(out_reg[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("hold mode changed output");
  property p_load;
    @(posedge clk_in) disable iff (!nrst_in) load_all |=> out_reg[1] == $past(in_reg[1]);
  endproperty
  a_load: assert property (p_load) else $error("load all missed channel");
  property p_inreg;
    @(posedge clk_in) disable iff (!nrst_in)
      (done && is_dac && !bcast) |=> in_reg[$past(dac_addr)] == $past(dac_data);
  endproperty
  a_inreg: assert property (p_inreg) else $error("input register not written");
  property p_bcast;
    @(posedge clk_in) disable iff (!nrst_in)
      (done && is_dac && bcast) |=>
        in_reg[3] == ($past(dac_cfg[3]) ? $past(dac_data) : $past(in_reg[3]));
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast missed channel");
  property p_pdall;
    @(posedge clk_in) disable iff (!nrst_in)
      global_power_down |=> (dac_drive_out == 8'h00 && !ref_en_out && !adc_buf_en_out);
  endproperty
  a_pdall: assert property (p_pdall) else $error("global power-down ignored");
  property p_pdkeep;
    @(posedge clk_in) disable iff (!nrst_in)
      pd_reg[2] |=> dac_code_out[2*CODE_W +: CODE_W] == $past(out_reg[2]);
  endproperty
  a_pdkeep: assert property (p_pdkeep) else $error("power-down lost code");
  property p_chpd;
    @(posedge clk_in) disable iff (!nrst_in) pd_reg[0] |=> !dac_drive_out[0];
  endproperty
  a_chpd: assert property (p_chpd) else $error("powered-down channel still drives");
  property p_track;
    @(posedge clk_in) disable iff (!nrst_in)
      (seq_wr && ctl_data[7:0] != 8'h00 && !global_power_down) |=> state == DS_TRACK;
  endproperty
  a_track: assert property (p_track) else $error("sequence write not tracking");
  // forty clocks, counted from the first converting cycle
  property p_conv;
    @(posedge clk_in) disable iff (!nrst_in)
      $rose(state == DS_CONV) |-> ##39 conv_end;
  endproperty
  a_conv: assert property (p_conv) else $error("conversion length wrong");
  property p_start;
    @(posedge clk_in) disable iff (!nrst_in)
      (state == DS_TRACK && fr.frame_start && !global_power_down && !seq_wr) |=>
        state == DS_CONV;
  endproperty
  a_start: assert property (p_start) else $error("select fall did not convert");
  property p_step;
    @(posedge clk_in) disable iff (!nrst_in)
      (conv_end && more_after(seq_sel, chan) && !seq_wr) |=>
        (state == DS_TRACK && chan > $past(chan) && seq_sel[chan]);
  endproperty
  a_step: assert property (p_step) else $error("sequencer did not step");
  property p_ctlkeep;
    @(posedge clk_in) disable iff (!nrst_in)
      (done && is_dac) |=> ($stable(gp_reg) && $stable(rb_reg) && $stable(pd_reg));
  endproperty
  a_ctlkeep: assert property (p_ctlkeep) else $error("dac frame changed a register");
  property p_rbwr;
    @(posedge clk_in) disable iff (!nrst_in)
      rb_wr |=> (mode == $past(ctl_word[1:0]) && rb_reg[10:7] == 4'h0);
  endproperty
  a_rbwr: assert property (p_rbwr) else $error("transfer mode not stored");
  property p_gpwr;
    @(posedge clk_in) disable iff (!nrst_in)
      gp_wr |=> (bcast == $past(ctl_word[GP_BCAST]) && gp_reg[3:0] == 4'h0 && !gp_reg[10]);
  endproperty
  a_gpwr: assert property (p_gpwr) else $error("general control not stored");
  property p_pdwr;
    @(posedge clk_in) disable iff (!nrst_in)
      pd_wr |=> (pd_reg[7:0] == $past(ctl_word[7:0]) &&
        pd_reg[PD_REF_BIT] == $past(ctl_word[PD_REF_BIT]));
  endproperty
  a_pdwr: assert property (p_pdwr) else $error("power-down register not stored");
  property p_range;
    @(posedge clk_in) disable iff (!nrst_in)
      gp_wr |=> ##1 (dac_gain2_out == $past(ctl_word[GP_DACR], 2) &&
        adc_gain2_out == $past(ctl_word[GP_ADCR], 2));
  endproperty
  a_range: assert property (p_range) else $error("range bits not applied");
  property p_outkeep;
    @(posedge clk_in) disable iff (!nrst_in)
      (done && is_dac && mode != MODE_IMM) |=> $stable(out_reg[5]);
  endproperty
  a_outkeep: assert property (p_outkeep) else $error("dac write moved an output");
  c_imm: cover property (@(posedge clk_in) done && is_dac && mode == MODE_IMM);
  c_load: cover property (@(posedge clk_in) load_all);
  c_bcast: cover property (@(posedge clk_in) done && is_dac && bcast);
  c_step: cover property (@(posedge clk_in) conv_end && more_after(seq_sel, chan));
  c_wrap: cover property (@(posedge clk_in) conv_end && !more_after(seq_sel, chan) && seq_rep);
endmodule
`default_nettype wire

// >>> dacseq_host.sv
// serial command master model for the frame port
`timescale 1ns/100ps
`default_nettype none
module dacseq_host (
  // alignment clock
  input wire logic clk_in,
  // serial port
  output logic sclk_out,
  output logic sync_n_out,
  output logic sdi_out
);
  initial begin
    sclk_out = 1'b1;
    sync_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #5;
  endtask
  // clock idles high, still between frames; data changes after rising edges
  task automatic send(input logic [15:0] f, input int nbits);
    sync_n_out = 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      sdi_out = f[i];
      tick(4);
      sclk_out = 1'b0;
      tick(4);
      sclk_out = 1'b1;
    end
    tick(4);
    sync_n_out = 1'b1;
    // line released: show a changed level, not the last bit
    sdi_out = ~sdi_out;
    // 600 ns gap covers tracking time and frame settling
    tick(12);
  endtask
endmodule
`default_nettype wire

// >>> tb_dacseq_top.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
module tb_dacseq_top;
  import dacseq_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  wire logic sclk_in;
  wire logic sync_n_in;
  wire logic sdi_in;
  logic [NCH*CODE_W-1:0] dac_code_out;
  logic [NCH-1:0] dac_drive_out;
  logic dac_gain2_out, adc_gain2_out, adc_buf_en_out, adc_prech_out;
  logic ref_en_out, lock_out, adc_track_out, adc_convert_out;
  logic [4:0] readback_sel_out;
  logic [2:0] adc_mux_out;
  int fails = 0;
  int comparisons = 0;
  logic [CODE_W-1:0] in_reg [NCH];
  logic [CODE_W-1:0] out_reg [NCH];
  logic [1:0] mode = 2'h0;
  logic bcast = 1'b0;
  logic [7:0] cfg = 8'h00;
  logic [4:0] sel;
  always #25 clk_in = ~clk_in;
  dacseq_host dacseq_host_i (.clk_in(clk_in), .sclk_out(sclk_in), .sync_n_out(sync_n_in),
    .sdi_out(sdi_in));
  dacseq_top dacseq_top_i (.clk_in, .nrst_in, .sclk_in, .sync_n_in, .sdi_in, .dac_code_out,
    .dac_drive_out, .dac_gain2_out, .adc_gain2_out, .adc_buf_en_out, .adc_prech_out,
    .ref_en_out, .lock_out, .readback_sel_out, .adc_mux_out, .adc_track_out,
    .adc_convert_out);
  function automatic logic [NCH*CODE_W-1:0] packed_out();
    logic [NCH*CODE_W-1:0] v;
    for (int n = 0; n < NCH; n++) v[n*CODE_W +: CODE_W] = out_reg[n];
    return v;
  endfunction
  task automatic chk(input string what, input logic [NCH*CODE_W-1:0] seen,
    input logic [NCH*CODE_W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // reserved bits always sent as zero by callers
  task automatic ctl(input logic [3:0] a, input logic [10:0] d);
    dacseq_host_i.send({1'b0, a, d}, 16);
    if (a == ADDR_RB) begin
      mode = d[1:0];
      if (d[1:0] == MODE_LOAD) out_reg = in_reg;
    end
    if (a == ADDR_GP) bcast = d[GP_BCAST];
    if (a == ADDR_DAC_CFG) cfg = d[7:0];
  endtask
  task automatic dac(input logic [2:0] ch, input logic [CODE_W-1:0] c);
    dacseq_host_i.send({1'b1, ch, c}, 16);
    for (int n = 0; n < NCH; n++) begin
      if (bcast ? cfg[n] : (n == ch)) begin
        in_reg[n] = c;
        if (mode == MODE_IMM) out_reg[n] = c;
      end
    end
  endtask
  task automatic conv_frame(input logic [4:0] nxt);
    fork
      ctl(ADDR_DAC_CFG, 11'h0ff);
      begin
        dacseq_host_i.tick(40);
        chk("converting", {adc_track_out, adc_convert_out}, 2'b01);
        dacseq_host_i.tick(10);
        chk("next", {adc_track_out, adc_convert_out, adc_track_out ? adc_mux_out : 3'h0},
          nxt);
      end
    join
  endtask
  initial begin
    #2_000_000;
    fails++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'hbfa33512));
    foreach (in_reg[n]) begin
      in_reg[n] = '0;
      out_reg[n] = '0;
    end
    dacseq_host_i.tick(8);
    nrst_in = 1'b1;
    dacseq_host_i.tick(4);
    chk("reset codes", dac_code_out, '0);
    chk("reset ctl", {dac_drive_out, dac_gain2_out, adc_gain2_out, adc_buf_en_out,
      adc_prech_out, ref_en_out, lock_out, readback_sel_out, adc_track_out, adc_convert_out,
      adc_mux_out}, '0);
    $display("done reset");
    ctl(ADDR_DAC_CFG, 11'h0ff);
    chk("drive", dac_drive_out, 8'hff);
    for (int n = 0; n < NCH; n++) begin
      dac(3'(n), n == 0 ? 12'h000 : n == 7 ? 12'hfff : 12'($urandom));
      chk("immediate", dac_code_out, packed_out());
    end
    dacseq_host_i.send({1'b1, 3'h1, 12'h5a5}, 15);
    chk("short frame", dac_code_out, packed_out());
    $display("done immediate");
    sel = 5'($urandom);
    ctl(ADDR_RB, {4'h0, sel, MODE_HOLD});
    chk("readback sel", readback_sel_out, sel);
    for (int n = 0; n < NCH; n++) begin
      dac(3'(n), 12'($urandom));
      chk("hold", dac_code_out, packed_out());
    end
    ctl(ADDR_RB, {4'h0, sel, MODE_LOAD});
    chk("load", dac_code_out, packed_out());
    $display("done synchronous");
    ctl(ADDR_RB, {4'h0, sel, MODE_IMM});
    ctl(ADDR_DAC_CFG, 11'h00f);
    ctl(ADDR_GP, 11'h3f0);
    chk("gp fields", {adc_prech_out, adc_buf_en_out, lock_out, adc_gain2_out,
      dac_gain2_out, dac_drive_out}, 13'h1f0f);
    dac(3'h6, 12'h2ff);
    chk("broadcast", dac_code_out, packed_out());
    $display("done broadcast");
    ctl(ADDR_DAC_CFG, 11'h0ff);
    ctl(ADDR_PD, 11'h205);
    chk("channel pd", {ref_en_out, dac_drive_out}, 9'h1fa);
    chk("pd codes", dac_code_out, packed_out());
    ctl(ADDR_PD, 11'h200);
    chk("resume", {ref_en_out, dac_drive_out}, 9'h1ff);
    ctl(ADDR_PD, 11'h600);
    chk("global pd", {ref_en_out, adc_buf_en_out, dac_drive_out}, '0);
    ctl(ADDR_PD, 11'h000);
    $display("done power down");
    ctl(ADDR_SEQ, 11'h00c);
    chk("first track", {adc_track_out, adc_convert_out, adc_mux_out}, 5'h12);
    conv_frame(5'h13);
    conv_frame(5'h00);
    ctl(ADDR_SEQ, 11'h20c);
    conv_frame(5'h13);
    conv_frame(5'h12);
    $display("done sequencer");
    end_of_test();
  end
endmodule
`default_nettype wire
